// ---- tpm_params.svh ----
// Register offsets, field positions, reset values and sizes of the timer PWM block
`ifndef TPM_PARAMS_SVH
`define TPM_PARAMS_SVH
`define TPM_OFS_CTRL 8'h00
`define TPM_OFS_MODE 8'h01
`define TPM_OFS_WAVE 8'h02
`define TPM_OFS_PRESCALE 8'h03
`define TPM_OFS_LO0 8'h04
`define TPM_OFS_HI0 8'h06
`define TPM_OFS_RL0 8'h08
`define TPM_OFS_RH0 8'h0A
`define TPM_OFS_STATUS 8'h0C
`define TPM_OFS_MASK 8'h0D
`define TPM_OFS_PINS 8'h0E
`define TPM_MODE_T1_LSB 4
`define TPM_PS_W 4
`define TPM_CNT_TOP 8'hFF
`define TPM_RST_BYTE 8'h00
`endif

// ---- tpm_pkg.sv ----
// Types shared by the timer PWM block
package tpm_pkg;
	typedef enum logic [1:0] {
		TPM_MODE0 = 2'b00,
		TPM_MODE1 = 2'b01,
		TPM_MODE2 = 2'b10,
		TPM_MODE3 = 2'b11
	} tpm_mode_t;
	typedef struct packed {
		logic gate;
		logic ctsel;
		tpm_mode_t mode;
	} tpm_tmode_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tpm_bus_req_t;
endpackage

// ---- tpm_timer_pwm.sv ----
// Two 8-bit timer pairs with PWM modes 1 to 3, register port and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "tpm_params.svh"
module tpm_timer_pwm #(
	parameter int PS_W = `TPM_PS_W
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire tpm_pkg::tpm_bus_req_t bus_in,
	output logic [7:0] rdata_out,
	input wire logic ext_request0_pin_in,
	input wire logic ext_request1_pin_in,
	input wire logic timer0_pin_in,
	output logic timer0_pin_out,
	output logic timer0_pin_oe_out,
	input wire logic timer1_pin_in,
	output logic timer1_pin_out,
	output logic timer1_pin_oe_out,
	output logic baud_tick_out,
	output logic irq_out
);
	import tpm_pkg::*;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	logic [1:0] run_reg;
	tpm_tmode_t tmode_reg [2];
	logic [1:0] wave_en_reg;
	logic [PS_W-1:0] tps_reg;
	logic [PS_W-1:0] ps_cnt_reg;
	logic [7:0] lo_reg [2];
	logic [7:0] hi_reg [2];
	logic [7:0] rl_reg [2];
	logic [7:0] rh_reg [2];
	logic [7:0] cmp_reg [2];
	logic [1:0] pin_reg;
	logic [1:0] pin_prev_reg;
	logic [1:0] status_reg;
	logic [1:0] mask_reg;
	logic baud_reg;
	logic [7:0] rdata_reg;

	logic [1:0] pin_in;
	logic tick;
	logic split;
	logic sh_step;
	logic t1_ovf;
	logic [1:0] en;
	logic [1:0] src;
	logic [1:0] step;
	logic [1:0] hi_step;
	logic [1:0] lo_top;
	logic [1:0] hi_top;
	logic [1:0] ev_ovf;
	logic [7:0] pc [2];
	logic [7:0] dv [2];
	logic [1:0] ps;
	logic [1:0] pw;
	logic [1:0] tg;
	logic [1:0] tev;
	logic wr_status;

	assign pin_in = {timer1_pin_in, timer0_pin_in};
	assign wr_status = bus_in.wr && hit(bus_in.addr, `TPM_OFS_STATUS);

	// Control and configuration registers
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			run_reg <= 2'h0;
			tmode_reg[0] <= tpm_tmode_t'(4'h0);
			tmode_reg[1] <= tpm_tmode_t'(4'h0);
			wave_en_reg <= 2'h0;
			tps_reg <= '0;
			mask_reg <= 2'h0;
		end else if (bus_in.wr) begin
			if (hit(bus_in.addr, `TPM_OFS_CTRL))
				run_reg <= bus_in.wdata[1:0];
			if (hit(bus_in.addr, `TPM_OFS_MODE)) begin
				tmode_reg[0] <= tpm_tmode_t'(bus_in.wdata[3:0]);
				tmode_reg[1] <= tpm_tmode_t'(bus_in.wdata[7:`TPM_MODE_T1_LSB]);
			end
			if (hit(bus_in.addr, `TPM_OFS_WAVE))
				wave_en_reg <= bus_in.wdata[1:0];
			if (hit(bus_in.addr, `TPM_OFS_PRESCALE))
				tps_reg <= bus_in.wdata[PS_W-1:0];
			if (hit(bus_in.addr, `TPM_OFS_MASK))
				mask_reg <= bus_in.wdata[1:0];
		end
	end

	// shared prescaler
	// Compare with >= so lowering the value never strands the count
	assign tick = (ps_cnt_reg >= tps_reg);
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in)
			ps_cnt_reg <= '0;
		else if (tick)
			ps_cnt_reg <= '0;
		else
			ps_cnt_reg <= ps_cnt_reg + 1'b1;
	end

	// Pins sampled for counter mode edges
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in)
			pin_prev_reg <= 2'h3;
		else
			pin_prev_reg <= pin_in;
	end

	assign split = (tmode_reg[0].mode == TPM_MODE3);

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			lo_top[i] = (lo_reg[i] == `TPM_CNT_TOP);
			hi_top[i] = (hi_reg[i] == `TPM_CNT_TOP);
			src[i] = tmode_reg[i].ctsel ? (pin_prev_reg[i] & ~pin_in[i]) : tick;
		end
		en[0] = run_reg[0] & (~tmode_reg[0].gate | ext_request0_pin_in);
		en[1] = run_reg[1] & (~tmode_reg[1].gate | ext_request1_pin_in);
		step[0] = en[0] & src[0];
		step[1] = en[1] & src[1] & (tmode_reg[1].mode != TPM_MODE3);
		// split high channel on timer 1 run
		sh_step = split & run_reg[1] & tick;
		for (int i = 0; i < 2; i++)
			hi_step[i] = (tmode_reg[i].mode inside {TPM_MODE0, TPM_MODE1})
				& step[i] & lo_top[i];
		hi_step[0] = hi_step[0] | sh_step;
		if (tmode_reg[0].mode inside {TPM_MODE2, TPM_MODE3})
			ev_ovf[0] = step[0] & lo_top[0];
		else
			ev_ovf[0] = hi_step[0] & hi_top[0];
		if (tmode_reg[1].mode == TPM_MODE2)
			t1_ovf = step[1] & lo_top[1];
		else
			t1_ovf = hi_step[1] & hi_top[1];
		ev_ovf[1] = split ? (sh_step & hi_top[0]) : t1_ovf;
	end

	// Per-pin waveform source
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			pc[i] = hi_reg[i];
			dv[i] = rh_reg[i];
			ps[i] = hi_step[i];
			pw[i] = hi_step[i] & hi_top[i];
			tg[i] = (tmode_reg[i].mode == TPM_MODE2);
			tev[i] = step[i] & lo_top[i];
		end
		if (split) begin
			pc[0] = lo_reg[0];
			dv[0] = rl_reg[0];
			ps[0] = step[0];
			pw[0] = step[0] & lo_top[0];
			tg[0] = 1'b0;
			pc[1] = hi_reg[0];
			dv[1] = rh_reg[0];
			ps[1] = sh_step;
			pw[1] = sh_step & hi_top[0];
			tg[1] = 1'b0;
		end
	end

	for (genvar g = 0; g < 2; g++) begin : g_timer
		logic wr_lo;
		logic wr_hi;
		assign wr_lo = bus_in.wr && hit(bus_in.addr, 8'(`TPM_OFS_LO0 + g));
		assign wr_hi = bus_in.wr && hit(bus_in.addr, 8'(`TPM_OFS_HI0 + g));

		always_ff @(posedge mclk_in) begin
			if (!rst_n_in) begin
				rl_reg[g] <= `TPM_RST_BYTE;
				rh_reg[g] <= `TPM_RST_BYTE;
			end else if (bus_in.wr) begin
				if (hit(bus_in.addr, 8'(`TPM_OFS_RL0 + g)))
					rl_reg[g] <= bus_in.wdata;
				if (hit(bus_in.addr, 8'(`TPM_OFS_RH0 + g)))
					rh_reg[g] <= bus_in.wdata;
			end
		end

		// Software write wins over a count step in the same cycle
		always_ff @(posedge mclk_in) begin
			if (!rst_n_in)
				lo_reg[g] <= `TPM_RST_BYTE;
			else if (wr_lo)
				lo_reg[g] <= bus_in.wdata;
			else if (step[g]) begin
				if (!lo_top[g])
					lo_reg[g] <= lo_reg[g] + 8'h01;
				// mode 2 reload from high count
				else if (tmode_reg[g].mode == TPM_MODE2)
					lo_reg[g] <= hi_reg[g];
				else if (tmode_reg[g].mode == TPM_MODE1)
					lo_reg[g] <= rl_reg[g];
				else
					lo_reg[g] <= `TPM_RST_BYTE;
			end
		end

		// high count is the mode 2 reload
		always_ff @(posedge mclk_in) begin
			if (!rst_n_in)
				hi_reg[g] <= `TPM_RST_BYTE;
			else if (wr_hi)
				hi_reg[g] <= bus_in.wdata;
			else if (hi_step[g])
				hi_reg[g] <= hi_reg[g] + 8'h01;
		end

		// Compare latch and pin level
		always_ff @(posedge mclk_in) begin
			if (!rst_n_in) begin
				cmp_reg[g] <= `TPM_RST_BYTE;
				pin_reg[g] <= 1'b0;
			end else if (tg[g]) begin
				if (tev[g])
					pin_reg[g] <= ~pin_reg[g];
			end else if (pw[g]) begin
				// 256-count period
				// A zero duty keeps the pin low through the wrap
				cmp_reg[g] <= dv[g];
				pin_reg[g] <= (dv[g] != 8'h00);
			end else if (ps[g] && (8'(pc[g] + 8'h01) == cmp_reg[g])) begin
				pin_reg[g] <= 1'b0;
			end
		end
	end

	// sticky flags, set wins over clear
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in)
			status_reg <= 2'h0;
		else
			status_reg <= (status_reg & ~(wr_status ? bus_in.wdata[1:0] : 2'h0)) | ev_ovf;
	end
	assign irq_out = |(status_reg & mask_reg);

	// timer 1 keeps feeding the baud tick
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in)
			baud_reg <= 1'b0;
		else
			baud_reg <= t1_ovf;
	end
	assign baud_tick_out = baud_reg;

	// drive pin only as timer output
	assign timer0_pin_out = pin_reg[0];
	assign timer1_pin_out = pin_reg[1];
	assign timer0_pin_oe_out = wave_en_reg[0] & ~tmode_reg[0].ctsel;
	assign timer1_pin_oe_out = wave_en_reg[1] & ~tmode_reg[1].ctsel;

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in)
			rdata_reg <= 8'h00;
		else if (!bus_in.rd)
			rdata_reg <= 8'h00;
		else begin
			unique case (bus_in.addr)
				`TPM_OFS_CTRL: rdata_reg <= {6'h00, run_reg};
				`TPM_OFS_MODE: rdata_reg <= {tmode_reg[1], tmode_reg[0]};
				`TPM_OFS_WAVE: rdata_reg <= {6'h00, wave_en_reg};
				`TPM_OFS_PRESCALE: rdata_reg <= 8'(tps_reg);
				8'h04: rdata_reg <= lo_reg[0];
				8'h05: rdata_reg <= lo_reg[1];
				8'h06: rdata_reg <= hi_reg[0];
				8'h07: rdata_reg <= hi_reg[1];
				8'h08: rdata_reg <= rl_reg[0];
				8'h09: rdata_reg <= rl_reg[1];
				8'h0A: rdata_reg <= rh_reg[0];
				8'h0B: rdata_reg <= rh_reg[1];
				`TPM_OFS_STATUS: rdata_reg <= {6'h00, status_reg};
				`TPM_OFS_MASK: rdata_reg <= {6'h00, mask_reg};
				`TPM_OFS_PINS: rdata_reg <= {6'h00, pin_reg};
				default: rdata_reg <= 8'h00;
			endcase
		end
	end
	assign rdata_out = rdata_reg;

	property p_lin_reload;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(tmode_reg[0].mode == TPM_MODE1) && step[0] && lo_top[0]
			&& !bus_in.wr |=> lo_reg[0] == $past(rl_reg[0]);
	endproperty
	a_lin_reload: assert property (p_lin_reload) else $error("low count not reloaded");

	property p_latch_load;
		@(posedge mclk_in) disable iff (!rst_n_in)
		!split && (tmode_reg[0].mode == TPM_MODE1) && pw[0]
			|=> cmp_reg[0] == $past(rh_reg[0]) && pin_reg[0] == ($past(rh_reg[0]) != 8'h00);
	endproperty
	a_latch_load: assert property (p_latch_load) else $error("latch or pin wrong at wrap");

	property p_match_low;
		@(posedge mclk_in) disable iff (!rst_n_in)
		!tg[0] && !pw[0] && ps[0] && (8'(pc[0] + 8'h01) == cmp_reg[0]) |=> !pin_reg[0];
	endproperty
	a_match_low: assert property (p_match_low) else $error("pin not cleared on match");

	property p_toggle;
		@(posedge mclk_in) disable iff (!rst_n_in)
		tg[0] && tev[0] |=> pin_reg[0] != $past(pin_reg[0]);
	endproperty
	a_toggle: assert property (p_toggle) else $error("mode 2 pin did not toggle");

	property p_m2_reload;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(tmode_reg[0].mode == TPM_MODE2) && step[0] && lo_top[0] && !bus_in.wr
			|=> lo_reg[0] == $past(hi_reg[0]) && $stable(hi_reg[0]);
	endproperty
	a_m2_reload: assert property (p_m2_reload) else $error("mode 2 reload wrong");

	property p_freeze;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(tmode_reg[1].mode == TPM_MODE3) && !bus_in.wr ##1 !bus_in.wr
			|-> $stable(lo_reg[1]) && $stable(hi_reg[1]);
	endproperty
	a_freeze: assert property (p_freeze) else $error("timer 1 moved in mode 3");

	property p_split_flag;
		@(posedge mclk_in) disable iff (!rst_n_in)
		split && sh_step && hi_top[0] |=> status_reg[1] ##1 status_reg[1] || $past(wr_status);
	endproperty
	a_split_flag: assert property (p_split_flag) else $error("split high flag missing");

	property p_tick_gap;
		@(posedge mclk_in) disable iff (!rst_n_in)
		// A prescale rewrite just after the tick may legally shorten the gap
		tick && (tps_reg == 4'h2) && $stable(tps_reg)
			|=> (!tick || tps_reg == 4'h0) ##1 (!tick || tps_reg <= 4'h1);
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("prescaler spacing wrong");

	property p_irq;
		@(posedge mclk_in) disable iff (!rst_n_in)
		ev_ovf[0] && mask_reg[0] && !(bus_in.wr && (bus_in.addr == `TPM_OFS_MASK))
			|=> irq_out;
	endproperty
	a_irq: assert property (p_irq) else $error("overflow raised no interrupt");

	property p_oe;
		@(posedge mclk_in) disable iff (!rst_n_in)
		tmode_reg[0].ctsel || !wave_en_reg[0] |-> !timer0_pin_oe_out;
	endproperty
	a_oe: assert property (p_oe) else $error("pin driven outside PWM");
endmodule // tpm_timer_pwm
`default_nettype wire

// ---- tpm_far_load.sv ----
// Model of the circuitry hanging on the two timer pins
`timescale 1ns/1ps
`default_nettype none
module tpm_far_load (
	input wire logic [1:0] drv_in,
	input wire logic [1:0] oe_in,
	input wire logic [1:0] ext_low_in,
	output logic [1:0] level_out
);
	// pin follows driver
	// Undriven pins float up through the port pull-up unless ext_low_in pulls them low
	assign level_out = (oe_in & drv_in) | (~oe_in & ~ext_low_in);
endmodule // tpm_far_load
`default_nettype wire

// ---- tb_timer_pwm_modes_one_to_three.sv ----
// Self-checking bench for the timer PWM block
`timescale 1ns/1ps
`default_nettype none
module tb_timer_pwm_modes_one_to_three;
	import tpm_pkg::*;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	tpm_bus_req_t bus_in = '0;
	logic [7:0] rdata_out;
	logic req0 = 1'b1;
	logic [1:0] pout, poe, plvl;
	logic [1:0] ext_low = 2'b00;
	logic baud, irq;
	logic [7:0] d, d2, a, b;
	int n_errors = 0;
	int n_compared = 0;
	int seed = 12656;
	int mirror [16] = '{default: 0};
	int ra [8] = '{1, 2, 3, 8, 9, 10, 11, 13};
	int rm [8] = '{255, 3, 15, 255, 255, 255, 255, 3};
	int pr, ph, k, n;
	always #50 mclk_in = ~mclk_in;
	tpm_timer_pwm uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .bus_in(bus_in),
		.rdata_out(rdata_out), .ext_request0_pin_in(req0), .ext_request1_pin_in(1'b1),
		.timer0_pin_in(plvl[0]), .timer0_pin_out(pout[0]), .timer0_pin_oe_out(poe[0]),
		.timer1_pin_in(plvl[1]), .timer1_pin_out(pout[1]), .timer1_pin_oe_out(poe[1]),
		.baud_tick_out(baud), .irq_out(irq));
	tpm_far_load far (.drv_in(pout), .oe_in(poe), .ext_low_in(ext_low), .level_out(plvl));
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0d seen %0d", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] v);
		@(posedge mclk_in);
		bus_in <= '{addr: ad, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge mclk_in);
		bus_in <= '0;
		mirror[ad[3:0]] = v;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [7:0] v);
		@(posedge mclk_in);
		bus_in <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk_in);
		bus_in <= '0;
		@(negedge mclk_in);
		v = rdata_out;
	endtask
	// Period and high time of one full cycle, starting at a rising edge
	task automatic meas(input int p, output int per, output int hi);
		int c;
		c = 0;
		per = 0;
		hi = 0;
		while (plvl[p] !== 1'b0 && c < 9000) begin @(negedge mclk_in); c++; end
		while (plvl[p] !== 1'b1 && c < 9000) begin @(negedge mclk_in); c++; end
		do begin
			hi += (plvl[p] === 1'b1);
			per++;
			@(negedge mclk_in);
		end while (!(plvl[p] === 1'b1 && per > hi) && per < 9000);
	endtask
	task automatic count_baud(output int cnt);
		cnt = 0;
		repeat (160) begin @(negedge mclk_in); cnt += (baud === 1'b1); end
	endtask
	function automatic int ps();
		return (mirror[3] & 15) + 1;
	endfunction
	task automatic summarize();
		if (n_errors == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (80000) @(posedge mclk_in);
		n_errors++;
		summarize();
	end
	initial begin
		repeat (12) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		for (k = 0; k < 16; k++) begin
			rd(k[7:0], d);
			chk("reset_value", d, 0);
		end
		@(negedge mclk_in);
		chk("rdata_idle", rdata_out, 0);
		for (k = 0; k < 8; k++) wr(ra[k][7:0], 8'($random(seed)));
		for (k = 0; k < 8; k++) begin
			rd(ra[k][7:0], d);
			chk("readback", d, mirror[ra[k]] & rm[k]);
		end
		// Mode 1 on timer 0, fastest prescale
		a = 8'($random(seed)) | 8'h01;
		wr(8'h03, 8'h00); wr(8'h08, 8'hFE); wr(8'h0A, a); wr(8'h0D, 8'h00);
		wr(8'h01, 8'h01); wr(8'h02, 8'h01); wr(8'h00, 8'h01);
		@(negedge mclk_in);
		chk("oe_mode1", poe, 2'b01);
		meas(0, pr, ph);
		chk("m1_period", pr, 256 * (256 - mirror[8]) * ps());
		chk("m1_high", ph, mirror[10] * (256 - mirror[8]) * ps());
		rd(8'h0C, d);
		chk("flag0", d[0], 1);
		chk("irq_masked", irq, 0);
		wr(8'h0D, 8'h01);
		@(negedge mclk_in);
		chk("irq_on", irq, 1);
		wr(8'h00, 8'h00); wr(8'h0C, 8'h03);
		@(negedge mclk_in);
		chk("irq_clear", irq, 0);
		// Timer 1 mirrors timer 0
		b = 8'($random(seed)) | 8'h01;
		wr(8'h03, 8'h01); wr(8'h09, 8'hFF); wr(8'h0B, b);
		wr(8'h01, 8'h10); wr(8'h02, 8'h02); wr(8'h00, 8'h02);
		meas(1, pr, ph);
		chk("t1_period", pr, 256 * (256 - mirror[9]) * ps());
		chk("t1_high", ph, mirror[11] * (256 - mirror[9]) * ps());
		// Mode 2, second pass with reload registers scribbled over
		wr(8'h00, 8'h00); wr(8'h03, 8'h02); wr(8'h06, 8'hF0);
		wr(8'h01, 8'h02); wr(8'h02, 8'h01); wr(8'h00, 8'h01);
		for (k = 0; k < 2; k++) begin
			if (k == 1) begin
				wr(8'h08, 8'($random(seed)));
				wr(8'h0A, 8'($random(seed)));
			end
			meas(0, pr, ph);
			chk("m2_period", pr, 2 * (256 - mirror[6]) * ps());
			chk("m2_high", ph, (256 - mirror[6]) * ps());
		end
		// Split mode on timer 0, timer 1 free for baud
		a = 8'($random(seed)) | 8'h01;
		b = 8'($random(seed)) | 8'h01;
		wr(8'h00, 8'h00); wr(8'h03, 8'h00); wr(8'h08, a); wr(8'h0A, b); wr(8'h07, 8'hF0);
		wr(8'h0C, 8'h03); wr(8'h01, 8'h23); wr(8'h02, 8'h03); wr(8'h00, 8'h03);
		meas(0, pr, ph);
		chk("m3_low_period", pr, 256 * ps());
		chk("m3_low_high", ph, mirror[8] * ps());
		meas(1, pr, ph);
		chk("m3_high_period", pr, 256 * ps());
		chk("m3_high_high", ph, mirror[10] * ps());
		rd(8'h0C, d);
		chk("flag1", d[1], 1);
		count_baud(n);
		chk("baud_run", n, 160 / ((256 - mirror[7]) * ps()));
		wr(8'h01, 8'h33);
		rd(8'h05, d);
		count_baud(n);
		chk("baud_stop", n, 0);
		rd(8'h05, d2);
		chk("t1_frozen", d2, d);
		// Gate holds the low channel while the request pin is low
		wr(8'h01, 8'h3B);
		@(posedge mclk_in);
		req0 <= 1'b0;
		rd(8'h04, d);
		repeat (40) @(negedge mclk_in);
		rd(8'h04, d2);
		chk("gate_hold", d2, d);
		@(posedge mclk_in);
		req0 <= 1'b1;
		repeat (40) @(negedge mclk_in);
		rd(8'h04, d);
		chk("gate_run", d != d2, 1);
		summarize();
	end
endmodule // tb_timer_pwm_modes_one_to_three
`default_nettype wire
